/* File: src/pal_defines.svh */
// Constants for the port alignment and link control block
`ifndef PAL_DEFINES_SVH
`define PAL_DEFINES_SVH
`define PAL_ID_W 7
`define PAL_ID_UB_ALL_REQ 7'h12
`define PAL_ID_UB_ALL_ACC 7'h13
`define PAL_ID_UB_ALL_REJ 7'h14
`define PAL_ID_UB_ALL_CMP 7'h15
`define PAL_ID_UB_PSTN_REQ 7'h16
`define PAL_ID_UB_PSTN_ACC 7'h17
`define PAL_ID_UB_PSTN_REJ 7'h18
`define PAL_ID_UB_PSTN_CMP 7'h19
`define PAL_ID_UB_ISDN_REQ 7'h1A
`define PAL_ID_UB_ISDN_ACC 7'h1B
`define PAL_ID_UB_ISDN_REJ 7'h1C
`define PAL_ID_UB_ISDN_CMP 7'h1D
`define PAL_ID_BL_PSTN_REQ 7'h1E
`define PAL_ID_BL_PSTN_ACC 7'h1F
`define PAL_ID_BL_PSTN_REJ 7'h20
`define PAL_ID_BL_PSTN_CMP 7'h21
`define PAL_ID_BL_ISDN_REQ 7'h22
`define PAL_ID_BL_ISDN_ACC 7'h23
`define PAL_ID_BL_ISDN_REJ 7'h24
`define PAL_ID_BL_ISDN_CMP 7'h25
`define PAL_ID_NONE 7'h7F
`define PAL_SUPPORT_ALL 5'h1F
`endif

/* File: src/pal_pkg.sv */
// Types for the port alignment and link control block
package pal_pkg;
  // Bulk procedures a) to e)
  typedef enum logic [2:0] {
    PAL_PROC_UB_ALL,
    PAL_PROC_UB_PSTN,
    PAL_PROC_UB_ISDN,
    PAL_PROC_BL_PSTN,
    PAL_PROC_BL_ISDN,
    PAL_PROC_NONE
  } pal_proc_t;
  // Message kind within a procedure
  typedef enum logic [1:0] {
    PAL_KIND_REQ,
    PAL_KIND_ACC,
    PAL_KIND_REJ,
    PAL_KIND_CMP
  } pal_kind_t;
  // A control function ID message on the peer channel
  typedef struct packed {
    logic valid;
    logic [6:0] id;
  } pal_msg_t;
  // Port-group commands toward the port state machines
  typedef struct packed {
    logic unblock_pstn;
    logic unblock_isdn_ba;
    logic unblock_isdn_pra;
    logic block_pstn;
    logic block_isdn_ba;
    logic block_isdn_pra;
    logic realign_unsuitable;
    logic unblock_unsuitable;
  } pal_port_cmd_t;
  // Management data units to system management
  typedef struct packed {
    logic link_available_mgmt_unit;
    logic link_unavailable;
    logic protocol_error;
  } pal_mdu_t;
endpackage

/* File: src/pal_link_ctrl.sv */
// Per-link layer 1 tracking and management primitive handling
`timescale 1ns/10ps
`default_nettype none
`include "pal_defines.svh"
module pal_link_ctrl
  import pal_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic layer1_activated_indication,
  input wire logic layer1_deactivated_indication,
  input wire logic mgmt_block,
  input wire logic mgmt_unblock,
  input wire logic peer_unblock_fe,
  output logic link_operational,
  output logic link_blocked,
  output logic link_available_pulse,
  output logic link_lost_pulse
);
  logic oper;
  logic blocked;
  // Layer 1 state follows indications; late peer reports are harmless
  wire next_oper = layer1_activated_indication ? 1'b1 :
    (layer1_deactivated_indication ? 1'b0 : oper);
  // Blocking by management; unblock needs both management and peer agree
  wire next_blocked = mgmt_block ? 1'b1 :
    ((mgmt_unblock && peer_unblock_fe) ? 1'b0 : blocked);
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      oper <= 1'b0;
      blocked <= 1'b0;
      link_available_pulse <= 1'b0;
      link_lost_pulse <= 1'b0;
    end
    else
    begin
      oper <= next_oper;
      blocked <= next_blocked;
      link_available_pulse <= next_oper && !oper;
      link_lost_pulse <= !next_oper && oper;
    end
  end
  assign link_operational = oper;
  assign link_blocked = blocked;
  chk_avail_on_recover: assert property (@(posedge clock) disable iff (rst)
    (!oper && layer1_activated_indication) |=> link_available_pulse)
    else $error("link availability not reported");
  chk_deact_drops_oper: assert property (@(posedge clock) disable iff (rst)
    (layer1_deactivated_indication && !layer1_activated_indication) |=> !link_operational)
    else $error("link stays operational after deactivation");
  chk_block_holds: assert property (@(posedge clock) disable iff (rst)
    mgmt_block |=> link_blocked)
    else $error("management block not applied");
endmodule
`default_nettype wire

/* File: src/pal_top.sv */
// Bulk port alignment command interpreter with per-link control
//
// Functional notes
// - Unblock-all-ISDN codes: request 1A, accepted 1B, rejected 1C, completed 1D.
// - Block-all-ISDN codes: request 22, accepted 23, rejected 24, completed 25.
// - Block-all-PSTN codes: request/accepted 1E-1F, rejected 20, completed 21.
// - ISDN bulk procedures cover basic access and primary rate ports.
// - Every bulk request gets the matching accepted or rejected answer.
// - Accepted bulk unblock unblocks relevant ports except unsuitable ones.
// - After unblock completes, unsuitable ports realign via port block indication.
// - Accepted bulk block blocks every addressed port.
// - After block completes, requester may unblock unsuitable ports per port.
// - Blocking entity unblocks when cause ends; either side may try.
// - Each procedure optional; unsupported requests get that procedure's reject.
// - Requesting side sends separate PSTN and ISDN unblock, not combined.
// - Each link has its own control: status, blocking, identification, protocol; pal_link_ctrl keeps only status and blocking.
// - Layer 1 reports status by activated and deactivated indications.
// - Link control exchanges primitives, data units and function elements.
// - Tolerate the two ends reporting layer 1 changes at different times.
// - On layer 1 recovery, signal link availability to system management.
// - Protocol errors are reported to system management as data units.
`timescale 1ns/10ps
`default_nettype none
`include "pal_defines.svh"
module pal_top
  import pal_pkg::*;
#(
  parameter logic [4:0] SUPPORT = `PAL_SUPPORT_ALL,
  parameter logic ACCEPT_ENABLE = 1'b1
)
(
  input wire logic clock,
  input wire logic rst,
  input wire pal_pkg::pal_msg_t rx_msg,
  input wire logic local_unblock_req,
  input wire logic local_block_pstn_req,
  input wire logic local_block_isdn_req,
  input wire logic local_complete,
  input wire logic cause_ceased,
  input wire logic layer1_activated_indication,
  input wire logic layer1_deactivated_indication,
  input wire logic mgmt_block,
  input wire logic mgmt_unblock,
  input wire logic peer_unblock_fe,
  output pal_pkg::pal_msg_t tx_msg,
  output pal_pkg::pal_port_cmd_t port_cmd,
  output logic port_block_indication,
  output logic port_unblock_request,
  output logic busy,
  output pal_pkg::pal_mdu_t management_data_unit,
  output logic link_operational,
  output logic link_blocked
);
  import pal_pkg::*;

  typedef enum logic [2:0] {
    PAL_IDLE,
    PAL_WAIT_ANSWER,
    PAL_ACTIVE,
    PAL_WAIT_CMP,
    PAL_SEND_CMP
  } pal_state_t;

  // Split an ID into procedure and message kind
  function automatic pal_proc_t id_proc(input logic [6:0] id);
    if (id >= `PAL_ID_UB_ALL_REQ && id <= `PAL_ID_UB_ALL_CMP)
      id_proc = PAL_PROC_UB_ALL;
    else if (id >= `PAL_ID_UB_PSTN_REQ && id <= `PAL_ID_UB_PSTN_CMP)
      id_proc = PAL_PROC_UB_PSTN;
    else if (id >= `PAL_ID_UB_ISDN_REQ && id <= `PAL_ID_UB_ISDN_CMP)
      id_proc = PAL_PROC_UB_ISDN;
    else if (id >= `PAL_ID_BL_PSTN_REQ && id <= `PAL_ID_BL_PSTN_CMP)
      id_proc = PAL_PROC_BL_PSTN;
    else if (id >= `PAL_ID_BL_ISDN_REQ && id <= `PAL_ID_BL_ISDN_CMP)
      id_proc = PAL_PROC_BL_ISDN;
    else
      id_proc = PAL_PROC_NONE;
  endfunction

  // Base code of a procedure; kind is added as an offset
  function automatic logic [6:0] proc_id(input pal_proc_t p, input pal_kind_t k);
    logic [6:0] base;
    base = `PAL_ID_NONE;
    unique case (p)
      PAL_PROC_UB_ALL: base = `PAL_ID_UB_ALL_REQ;
      PAL_PROC_UB_PSTN: base = `PAL_ID_UB_PSTN_REQ;
      PAL_PROC_UB_ISDN: base = `PAL_ID_UB_ISDN_REQ;
      PAL_PROC_BL_PSTN: base = `PAL_ID_BL_PSTN_REQ;
      PAL_PROC_BL_ISDN: base = `PAL_ID_BL_ISDN_REQ;
      default: base = `PAL_ID_NONE;
    endcase
    proc_id = (p == PAL_PROC_NONE) ? `PAL_ID_NONE : base + {5'h00, k};
  endfunction

  function automatic pal_kind_t id_kind(input logic [6:0] id);
    logic [6:0] d;
    d = id - proc_id(id_proc(id), PAL_KIND_REQ);
    id_kind = pal_kind_t'(d[1:0]);
  endfunction

  pal_state_t state;
  pal_proc_t proc;
  logic pending_isdn;
  logic requester;

  // Receive decode
  wire pal_proc_t rx_proc = id_proc(rx_msg.id);
  wire pal_kind_t rx_kind = id_kind(rx_msg.id);
  wire rx_reserved = rx_msg.valid && (rx_proc == PAL_PROC_NONE);
  wire rx_req = rx_msg.valid && !rx_reserved && rx_kind == PAL_KIND_REQ;
  // Support map widened so the reserved procedure code indexes a zero
  wire [7:0] support_map = {3'h0, SUPPORT};
  wire rx_supported = support_map[rx_proc] && ACCEPT_ENABLE;
  wire rx_match = rx_msg.valid && !rx_reserved && rx_proc == proc;
  wire rx_acc = rx_match && rx_kind == PAL_KIND_ACC;
  wire rx_rej = rx_match && rx_kind == PAL_KIND_REJ;
  wire rx_cmp = rx_match && rx_kind == PAL_KIND_CMP;
  wire rx_unexpected = rx_msg.valid && !rx_reserved && !rx_req &&
    (state != PAL_WAIT_ANSWER || !rx_match) && !(state == PAL_WAIT_CMP && rx_cmp);
  wire is_unblock = proc == PAL_PROC_UB_ALL || proc == PAL_PROC_UB_PSTN ||
    proc == PAL_PROC_UB_ISDN;
  // Local requests; unblock issued as separate PSTN then ISDN
  wire start_local = state == PAL_IDLE && !rx_msg.valid &&
    (local_unblock_req || local_block_pstn_req || local_block_isdn_req || pending_isdn);
  wire pal_proc_t local_proc = pending_isdn ? PAL_PROC_UB_ISDN :
    local_unblock_req ? PAL_PROC_UB_PSTN :
    local_block_pstn_req ? PAL_PROC_BL_PSTN : PAL_PROC_BL_ISDN;

  // Next state logic
  pal_state_t next_state;
  pal_proc_t next_proc;
  always_comb
  begin
    next_state = state;
    next_proc = proc;
    unique case (state)
      PAL_IDLE:
      begin
        if (rx_req && rx_supported)
        begin
          next_state = PAL_ACTIVE;
          next_proc = rx_proc;
        end
        else if (start_local)
        begin
          next_state = PAL_WAIT_ANSWER;
          next_proc = local_proc;
        end
      end
      PAL_WAIT_ANSWER:
      begin
        if (rx_acc)
          next_state = PAL_SEND_CMP;
        else if (rx_rej)
          next_state = PAL_IDLE;
      end
      PAL_ACTIVE:
        next_state = PAL_WAIT_CMP;
      PAL_WAIT_CMP:
      begin
        if (rx_cmp)
          next_state = PAL_IDLE;
      end
      PAL_SEND_CMP:
      begin
        if (local_complete)
          next_state = PAL_IDLE;
      end
    endcase
  end

  // Outgoing message selection
  wire pal_kind_t answer_kind = rx_supported ? PAL_KIND_ACC : PAL_KIND_REJ;
  wire answer_now = state == PAL_IDLE && rx_req;
  wire busy_reject = state != PAL_IDLE && rx_req;
  wire pal_msg_t next_tx =
    answer_now ? pal_msg_t'{valid: 1'b1, id: proc_id(rx_proc, answer_kind)} :
    busy_reject ? pal_msg_t'{valid: 1'b1, id: proc_id(rx_proc, PAL_KIND_REJ)} :
    start_local ? pal_msg_t'{valid: 1'b1, id: proc_id(local_proc, PAL_KIND_REQ)} :
    (state == PAL_SEND_CMP && local_complete) ?
      pal_msg_t'{valid: 1'b1, id: proc_id(proc, PAL_KIND_CMP)} :
    pal_msg_t'{valid: 1'b0, id: `PAL_ID_NONE};

  // Port commands on acceptance, completion or ceased cause; ISDN covers BA and PRA
  wire accepted = (state == PAL_IDLE && rx_req && rx_supported) || rx_acc;
  wire pal_proc_t acc_proc = (state == PAL_IDLE) ? rx_proc : proc;
  wire ub_p = acc_proc == PAL_PROC_UB_ALL || acc_proc == PAL_PROC_UB_PSTN;
  wire ub_i = acc_proc == PAL_PROC_UB_ALL || acc_proc == PAL_PROC_UB_ISDN;
  wire done = (state == PAL_WAIT_CMP && rx_cmp) ||
    (state == PAL_SEND_CMP && local_complete);
  wire pal_port_cmd_t next_cmd = '{
    unblock_pstn: accepted && ub_p,
    unblock_isdn_ba: accepted && ub_i,
    unblock_isdn_pra: accepted && ub_i,
    block_pstn: accepted && acc_proc == PAL_PROC_BL_PSTN,
    block_isdn_ba: accepted && acc_proc == PAL_PROC_BL_ISDN,
    block_isdn_pra: accepted && acc_proc == PAL_PROC_BL_ISDN,
    realign_unsuitable: done && is_unblock,
    unblock_unsuitable: (done && !is_unblock && requester) || cause_ceased
  };

  logic l1_up;
  logic l1_down;
  pal_link_ctrl u_link (
    .clock(clock),
    .rst(rst),
    .layer1_activated_indication(layer1_activated_indication),
    .layer1_deactivated_indication(layer1_deactivated_indication),
    .mgmt_block(mgmt_block),
    .mgmt_unblock(mgmt_unblock),
    .peer_unblock_fe(peer_unblock_fe),
    .link_operational(link_operational),
    .link_blocked(link_blocked),
    .link_available_pulse(l1_up),
    .link_lost_pulse(l1_down)
  );

  // Registers and outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state <= PAL_IDLE;
      proc <= PAL_PROC_NONE;
      pending_isdn <= 1'b0;
      requester <= 1'b0;
      tx_msg <= '{valid: 1'b0, id: `PAL_ID_NONE};
      port_cmd <= '0;
      port_block_indication <= 1'b0;
      port_unblock_request <= 1'b0;
      busy <= 1'b0;
      management_data_unit <= '0;
    end
    else
    begin
      state <= next_state;
      proc <= next_proc;
      requester <= start_local ? 1'b1 : (answer_now ? 1'b0 : requester);
      pending_isdn <= (start_local && local_unblock_req && !pending_isdn) ? 1'b1 :
        ((start_local && pending_isdn) ? 1'b0 : pending_isdn);
      tx_msg <= next_tx;
      port_cmd <= next_cmd;
      port_block_indication <= next_cmd.realign_unsuitable;
      port_unblock_request <= next_cmd.unblock_unsuitable;
      busy <= next_state != PAL_IDLE;
      management_data_unit <= '{link_available_mgmt_unit: l1_up, link_unavailable: l1_down,
        protocol_error: rx_reserved || rx_unexpected};
    end
  end

  // Answers to received requests and their codes
  chk_req_answered: assert property (@(posedge clock) disable iff (rst)
    (state == PAL_IDLE && rx_req) |=> tx_msg.valid &&
    (tx_msg.id == $past(rx_msg.id) + 7'h01 || tx_msg.id == $past(rx_msg.id) + 7'h02))
    else $error("bulk request not answered");
  chk_unsup_reject: assert property (@(posedge clock) disable iff (rst)
    (state == PAL_IDLE && rx_req && !rx_supported) |=>
    tx_msg.id == $past(rx_msg.id) + 7'h02)
    else $error("unsupported request not rejected");
  chk_isdn_code: assert property (@(posedge clock) disable iff (rst)
    (state == PAL_IDLE && rx_msg.valid && rx_msg.id == `PAL_ID_UB_ISDN_REQ && rx_supported)
    |=> tx_msg.id == `PAL_ID_UB_ISDN_ACC)
    else $error("wrong ISDN unblock accept code");
  chk_busy_reject: assert property (@(posedge clock) disable iff (rst)
    (state != PAL_IDLE && rx_req) |=> tx_msg.valid &&
    tx_msg.id == $past(rx_msg.id) + 7'h02)
    else $error("request while busy not rejected");
  // Port group commands after acceptance and completion
  chk_block_isdn: assert property (@(posedge clock) disable iff (rst)
    (accepted && acc_proc == PAL_PROC_BL_ISDN) |=>
    port_cmd.block_isdn_ba && port_cmd.block_isdn_pra)
    else $error("ISDN block misses an access type");
  chk_unblock_all: assert property (@(posedge clock) disable iff (rst)
    (accepted && acc_proc == PAL_PROC_UB_ALL) |=> port_cmd.unblock_pstn &&
    port_cmd.unblock_isdn_ba && port_cmd.unblock_isdn_pra)
    else $error("combined unblock misses a port group");
  chk_block_pstn: assert property (@(posedge clock) disable iff (rst)
    (accepted && acc_proc == PAL_PROC_BL_PSTN) |=> port_cmd.block_pstn &&
    !port_cmd.unblock_pstn)
    else $error("PSTN block not applied");
  chk_realign_ind: assert property (@(posedge clock) disable iff (rst)
    (done && is_unblock) |=> port_block_indication)
    else $error("unsuitable ports not realigned");
  chk_unsuit_unblock: assert property (@(posedge clock) disable iff (rst)
    (done && !is_unblock && requester) |=> port_unblock_request)
    else $error("unsuitable ports not offered unblocking");
  chk_cause_unblock: assert property (@(posedge clock) disable iff (rst)
    cause_ceased |=> port_unblock_request)
    else $error("unblock not requested after cause ended");
  // Local requests use only the separate procedures
  chk_no_combined: assert property (@(posedge clock) disable iff (rst)
    start_local |=> tx_msg.valid && tx_msg.id inside {`PAL_ID_UB_PSTN_REQ,
    `PAL_ID_UB_ISDN_REQ, `PAL_ID_BL_PSTN_REQ, `PAL_ID_BL_ISDN_REQ})
    else $error("combined unblock issued");
  // Data units toward system management
  chk_reserved_err: assert property (@(posedge clock) disable iff (rst)
    rx_reserved |=> management_data_unit.protocol_error)
    else $error("reserved code not reported");
  chk_avail_mdu: assert property (@(posedge clock) disable iff (rst)
    l1_up |=> management_data_unit.link_available_mgmt_unit)
    else $error("availability unit missing");
  // Main scenarios
  cov_remote_unblock: cover property (@(posedge clock) disable iff (rst)
    state == PAL_IDLE && rx_req ##1 state == PAL_ACTIVE ##[1:20] rx_cmp);
  cov_local_block: cover property (@(posedge clock) disable iff (rst)
    rx_acc && proc == PAL_PROC_BL_PSTN);
  cov_reject: cover property (@(posedge clock) disable iff (rst) rx_rej);
  cov_busy_reject: cover property (@(posedge clock) disable iff (rst) busy_reject);
  cov_isdn_follow: cover property (@(posedge clock) disable iff (rst)
    start_local && pending_isdn);
endmodule
`default_nettype wire

/* File: tb/pal_peer_model.sv */
// Peer entity that answers the bulk requests sent by the block
`timescale 1ns/10ps
`default_nettype none
module pal_peer_model
  import pal_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire pal_pkg::pal_msg_t tx_msg,
  input wire logic accept,
  input wire logic [1:0] delay,
  input wire logic inj_valid,
  input wire logic [6:0] inj_id,
  output pal_pkg::pal_msg_t rx_msg
);
  import pal_pkg::*;
  pal_msg_t ans = 8'h00;
  logic pend = 1'b0;
  logic [6:0] pid = 7'h00;
  logic [1:0] cnt = 2'h0;
  wire logic is_req;
  // Request codes of the five bulk procedures
  assign is_req = tx_msg.id inside {7'h12, 7'h16, 7'h1A, 7'h1E, 7'h22};
  // Injected traffic wins over answers
  assign rx_msg = inj_valid ? {1'b1, inj_id} : ans;
  // Answer each request after a short delay
  always @(negedge clock)
  begin
    ans.valid <= 1'b0;
    ans.id <= ~ans.id; // Idle id never holds its last value
    if (rst)
      pend <= 1'b0;
    else if (pend)
    begin
      if (cnt == 2'h0)
      begin
        ans <= {1'b1, pid};
        pend <= 1'b0;
      end
      else
        cnt <= cnt - 2'h1;
    end
    else if (tx_msg.valid && is_req)
    begin
      pend <= 1'b1;
      pid <= accept ? tx_msg.id + 7'h1 : tx_msg.id + 7'h2;
      cnt <= delay;
    end
  end
endmodule
`default_nettype wire

/* File: tb/pal_top_tb_top.sv */
// Self-checking bench for the bulk alignment block
`timescale 1ns/10ps
`default_nettype none
module pal_top_tb_top;
  import pal_pkg::*;
  logic clock;
  logic rst;
  logic [9:0] pin;
  logic accept;
  logic [1:0] delay;
  logic inj_valid;
  logic [6:0] inj_id;
  logic [15:0] lfsr;
  logic [15:0] e;
  logic [7:0] cmd_seen = 8'h00;
  pal_msg_t rx_msg;
  pal_msg_t tx_msg;
  pal_port_cmd_t port_cmd;
  pal_mdu_t management_data_unit;
  logic pbi, pur, busy, lop, lbl;
  logic [15:0] expq[$];
  logic [6:0] req[4] = '{7'h12, 7'h16, 7'h1A, 7'h22};
  logic [7:0] cmd[4] = '{8'hE0, 8'h80, 8'h60, 8'h0C};
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  wire logic [6:0] flags;
  assign flags = {management_data_unit, pbi, pur, lbl, lop};
  pal_top #(.SUPPORT(5'h17), .ACCEPT_ENABLE(1'b1)) dut (
    .clock(clock), .rst(rst), .rx_msg(rx_msg),
    .local_unblock_req(pin[0]), .local_block_pstn_req(pin[1]),
    .local_block_isdn_req(pin[2]), .local_complete(pin[3]),
    .cause_ceased(pin[4]), .layer1_activated_indication(pin[5]),
    .layer1_deactivated_indication(pin[6]), .mgmt_block(pin[7]),
    .mgmt_unblock(pin[8]), .peer_unblock_fe(pin[9]),
    .tx_msg(tx_msg), .port_cmd(port_cmd), .port_block_indication(pbi),
    .port_unblock_request(pur), .busy(busy), .management_data_unit(management_data_unit),
    .link_operational(lop), .link_blocked(lbl));
  pal_peer_model peer (
    .clock(clock), .rst(rst), .tx_msg(tx_msg), .accept(accept),
    .delay(delay), .inj_valid(inj_valid), .inj_id(inj_id), .rx_msg(rx_msg));
  // Clock generation
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic close_out;
    $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic pulse(input logic [9:0] m);
    @(negedge clock);
    pin = m;
    @(negedge clock);
    pin = 10'h000;
  endtask
  task automatic inj(input logic [6:0] id);
    @(negedge clock);
    inj_valid = 1'b1;
    inj_id = id;
    @(negedge clock);
    inj_valid = 1'b0;
    inj_id = ~id;
  endtask
  task automatic drain;
    for (int n = 0; n < 40 && expq.size() != 0; n++)
      @(negedge clock);
    chk("pending answers", 8'h00, 8'(expq.size()));
    repeat (6) @(negedge clock);
  endtask
  task automatic wait_bit(input int b, input logic want, input string nm);
    for (int n = 0; n < 8 && flags[b] !== want; n++)
      @(negedge clock);
    chk(nm, {7'h0, want}, {7'h0, flags[b]});
  endtask
  // Monitor: each sent message takes the oldest expectation
  always @(negedge clock)
    if (rst === 1'b0 && tx_msg.valid === 1'b1)
    begin
      if (expq.size() == 0)
        chk("spare tx id", 8'hFF, {1'b0, tx_msg.id});
      else
      begin
        e = expq.pop_front();
        chk("tx id", {1'b0, e[6:0]}, {1'b0, tx_msg.id});
        if (e[15])
          chk("port cmd", e[14:7], port_cmd);
      end
    end
  // Collect port commands that come without a message
  always @(negedge clock)
    cmd_seen = cmd_seen | port_cmd;
  // Hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    pin = 10'h000;
    accept = 1'b1;
    delay = 2'h0;
    inj_valid = 1'b0;
    inj_id = 7'h00;
    lfsr = 16'h3609;
    rst = 1'b1;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    chk("tx reset", 8'h7F, tx_msg);
    chk("cmd reset", 8'h00, port_cmd);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      expq.push_back({1'b1, cmd[i], req[i] + 7'h1});
      inj(req[i]);
      chk("busy", 8'h01, {7'h0, busy});
      inj(req[i] + 7'h3);
      chk("realign", (i < 3) ? 8'h02 : 8'h00, port_cmd);
      chk("block ind", (i < 3) ? 8'h01 : 8'h00, {7'h0, pbi});
      chk("idle", 8'h00, {7'h0, busy});
    end
    $display("test peer requests done");
    expq.push_back({1'b1, 8'h60, 7'h1B});
    inj(7'h1A);
    expq.push_back({1'b1, 8'h00, 7'h18});
    inj(7'h16);
    inj(7'h1D);
    expq.push_back({1'b1, 8'h00, 7'h20});
    inj(7'h1E);
    drain();
    $display("test refusals done");
    repeat (3)
    begin
      lfsr = step(lfsr);
      inj(7'h26 + lfsr[6:0] % 7'h58);
      chk("reserved", 8'h01, {7'h0, flags[4]});
    end
    inj(7'h1D);
    chk("unmatched", 8'h01, {7'h0, flags[4]});
    $display("test protocol errors done");
    lfsr = step(lfsr);
    delay = lfsr[1:0];
    expq.push_back({1'b0, 8'h00, 7'h16});
    pulse(10'h001);
    drain();
    expq.push_back({1'b0, 8'h00, 7'h19});
    expq.push_back({1'b0, 8'h00, 7'h1A});
    pulse(10'h008);
    drain();
    expq.push_back({1'b0, 8'h00, 7'h1D});
    pulse(10'h008);
    drain();
    chk("local idle", 8'h00, {7'h0, busy});
    accept = 1'b0;
    expq.push_back({1'b0, 8'h00, 7'h22});
    pulse(10'h004);
    drain();
    chk("rejected idle", 8'h00, {7'h0, busy});
    accept = 1'b1;
    expq.push_back({1'b0, 8'h00, 7'h1E});
    pulse(10'h002);
    cmd_seen = 8'h00;
    drain();
    chk("local accept cmd", 8'h10, cmd_seen);
    chk("await complete", 8'h01, {7'h0, busy});
    expq.push_back({1'b0, 8'h00, 7'h21});
    pulse(10'h008);
    chk("unsuitable unblock", 8'h01, {7'h0, pur});
    chk("unblock cmd", 8'h01, port_cmd);
    drain();
    $display("test local requests done");
    pulse(10'h010);
    wait_bit(2, 1'b1, "unblock req");
    pulse(10'h020);
    wait_bit(6, 1'b1, "link avail");
    chk("link oper", 8'h01, {7'h0, lop});
    pulse(10'h080);
    wait_bit(1, 1'b1, "link blocked");
    pulse(10'h300);
    wait_bit(1, 1'b0, "link unblocked");
    pulse(10'h040);
    wait_bit(5, 1'b1, "link lost");
    chk("link down", 8'h00, {7'h0, lop});
    $display("test link control done");
    close_out();
  end
endmodule
`default_nettype wire
